// File: ssf_supervisor.sv
// fault supervisor and two-wire register slave of a lamp inverter controller
// assumes link_clk oversamples the bus pins; light_sensor_code is on link_clk
`timescale 1ns/10ps
module ssf_supervisor #(
   parameter int unsigned FAULT_LIMIT = ssf_pkg::TIMER_LIMIT,
   parameter int unsigned UV_DELAY = ssf_pkg::UV_CYCLES
) (
   // system
   input wire logic sys_clk,
   input wire logic rst_b,
   // two-wire link
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // analog comparators, asynchronous
   input wire logic lamp_a_low,
   input wire logic lamp_b_low,
   input wire logic sec_over_v,
   input wire logic sec_over_i,
   input wire logic prim_over_i,
   input wire logic sec_under_v,
   input wire logic supply_lockout,
   input wire logic low_side_phase,
   input wire logic dimming_chop,
   input wire logic lamp_a_on,
   input wire logic lamp_b_on,
   // light sensor converter
   input wire logic [7:0] light_sensor_code,
   // controls
   output logic [7:0] brightness_level,
   output logic high_side_en,
   output logic low_side_en,
   output logic high_side_cut,
   output logic comp_discharge,
   output logic light_sensor_supply
);
   typedef struct packed {
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      ssf_pkg::ssf_link_st_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] tx;
      logic rd;
      logic [2:0] cmd;
      logic [7:0] wdata;
      logic have_data;
      logic [7:0] bright;
      logic [7:0] ctrl;
      logic [7:0] low;
      logic [7:0] high;
      logic [1:0] fault_s;
      logic [1:0] ovc_s;
      logic [1:0] lamp_s;
      logic sda_oe;
      logic sda_out;
   } ssf_link_t;
   typedef struct packed {
      logic [ssf_pkg::CMP_N-1:0] cmp_m;
      logic [ssf_pkg::CMP_N-1:0] cmp_s;
      logic [1:0] en_s;
      logic [ssf_pkg::TIMER_W-1:0] timer;
      logic [16:0] uv_cnt;
      logic lamp_fault;
      logic oc_fault;
      logic uv_shut;
      logic hs_en;
      logic ls_en;
      logic hs_cut;
      logic disch;
      logic lss;
   } ssf_core_t;
   ssf_link_t l;
   ssf_link_t next_l;
   ssf_core_t c;
   ssf_core_t next_c;
   localparam ssf_link_t LINK_RST = '{
      scl_s: 3'h7, sda_s: 3'h7, st: ssf_pkg::LS_IDLE, cnt: 4'h0, sh: 8'h00,
      tx: 8'h00, rd: 1'b0, cmd: 3'h0, wdata: 8'h00, have_data: 1'b0,
      bright: ssf_pkg::BRIGHT_RST, ctrl: ssf_pkg::CTRL_RST,
      low: ssf_pkg::LOW_RST, high: ssf_pkg::HIGH_RST,
      fault_s: 2'h0, ovc_s: 2'h0, lamp_s: 2'h0, sda_oe: 1'b0, sda_out: 1'b0};
   function automatic logic [7:0] reg_read(input ssf_link_t r, input logic [7:0] light);
      logic [7:0] v;
      v = 8'h00;
      case (r.cmd)
         ssf_pkg::OFF_BRIGHT: v = r.bright;
         ssf_pkg::OFF_CTRL: v = r.ctrl;
         ssf_pkg::OFF_STATUS:
         begin
            v[ssf_pkg::STAT_FAULT_BIT] = r.fault_s[1];
            v[ssf_pkg::STAT_OVC_BIT] = r.ovc_s[1];
            v[ssf_pkg::STAT_LAMP_BIT] = r.lamp_s[1];
         end
         ssf_pkg::OFF_ID: v = ssf_pkg::PART_ID;
         ssf_pkg::OFF_LIGHT: v = light;
         ssf_pkg::OFF_LOW: v = r.low;
         ssf_pkg::OFF_HIGH: v = r.high;
         default: v = 8'h00;
      endcase
      return v;
   endfunction
   // link side: pins pass three flops, edges are taken from the second and third
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic [7:0] rd_val;
   always_comb
   begin
      next_l = l;
      rd_val = reg_read(l, light_sensor_code);
      next_l.scl_s = {l.scl_s[1:0], scl_in};
      next_l.sda_s = {l.sda_s[1:0], sda_in};
      next_l.fault_s = {l.fault_s[0], c.lamp_fault | c.oc_fault};
      next_l.ovc_s = {l.ovc_s[0], c.oc_fault};
      next_l.lamp_s = {l.lamp_s[0],
         c.cmp_s[ssf_pkg::CMP_LAMP_A_ON] & c.cmp_s[ssf_pkg::CMP_LAMP_B_ON]};
      scl_rise = l.scl_s[1] & ~l.scl_s[2];
      scl_fall = ~l.scl_s[1] & l.scl_s[2];
      bus_start = l.scl_s[1] & l.scl_s[2] & ~l.sda_s[1] & l.sda_s[2];
      bus_stop = l.scl_s[1] & l.scl_s[2] & l.sda_s[1] & ~l.sda_s[2];
      if (bus_start || bus_stop) // no enable gating keeps the bus alive in shutdown
      begin
         // a write commits only once its data byte was acknowledged
         if (l.have_data)
         begin
            case (l.cmd)
               ssf_pkg::OFF_BRIGHT:
               begin
                  // outside the bus-set mode the brightness register ignores writes
                  if (!l.ctrl[ssf_pkg::CTRL_SENSOR_BIT] && !l.ctrl[ssf_pkg::CTRL_PWM_SEL_BIT])
                     next_l.bright = l.wdata;
               end
               ssf_pkg::OFF_CTRL: next_l.ctrl = l.wdata & ssf_pkg::CTRL_MASK;
               ssf_pkg::OFF_LOW: next_l.low = l.wdata;
               ssf_pkg::OFF_HIGH: next_l.high = l.wdata;
               default: next_l.have_data = 1'b0;
            endcase
         end
         next_l.have_data = 1'b0;
         next_l.sda_oe = 1'b0;
         next_l.cnt = 4'h0;
         next_l.st = bus_start ? ssf_pkg::LS_ADDR : ssf_pkg::LS_IDLE;
      end
      else
      begin
         case (l.st)
            ssf_pkg::LS_IDLE, ssf_pkg::LS_WAIT: next_l.st = l.st;
            ssf_pkg::LS_ADDR, ssf_pkg::LS_CMD, ssf_pkg::LS_DATA:
            begin
               if (scl_rise)
               begin
                  next_l.sh = {l.sh[6:0], l.sda_s[1]};
                  next_l.cnt = l.cnt + 4'h1;
               end
               else if (scl_fall && l.cnt == ssf_pkg::BITS_PER_BYTE)
               begin
                  next_l.st = ssf_pkg::LS_WAIT;
                  if (l.st == ssf_pkg::LS_ADDR && l.sh[7:1] == ssf_pkg::SLAVE_ADDR)
                  begin
                     next_l.sda_oe = 1'b1;
                     next_l.rd = l.sh[0];
                     next_l.st = ssf_pkg::LS_ADDR_ACK;
                  end
                  else if (l.st == ssf_pkg::LS_CMD && l.sh <= ssf_pkg::CMD_LAST)
                  begin
                     next_l.sda_oe = 1'b1;
                     next_l.cmd = l.sh[2:0];
                     next_l.st = ssf_pkg::LS_CMD_ACK;
                  end
                  else if (l.st == ssf_pkg::LS_DATA)
                  begin
                     next_l.sda_oe = 1'b1;
                     next_l.wdata = l.sh;
                     next_l.have_data = 1'b1;
                     next_l.st = ssf_pkg::LS_DATA_ACK;
                  end
               end
            end
            ssf_pkg::LS_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  if (l.rd)
                  begin
                     // first data bit goes out on the fall that ends the ack
                     next_l.tx = {rd_val[6:0], 1'b0};
                     next_l.sda_oe = ~rd_val[7];
                     next_l.cnt = 4'h1;
                     next_l.st = ssf_pkg::LS_READ;
                  end
                  else
                  begin
                     next_l.sda_oe = 1'b0;
                     next_l.cnt = 4'h0;
                     next_l.st = ssf_pkg::LS_CMD;
                  end
               end
            end
            ssf_pkg::LS_CMD_ACK, ssf_pkg::LS_DATA_ACK:
            begin
               if (scl_fall) // bytes after the data byte are not acknowledged
               begin
                  next_l.sda_oe = 1'b0;
                  next_l.cnt = 4'h0;
                  next_l.st = (l.st == ssf_pkg::LS_CMD_ACK) ? ssf_pkg::LS_DATA : ssf_pkg::LS_WAIT;
               end
            end
            ssf_pkg::LS_READ:
            begin
               if (scl_fall)
               begin
                  if (l.cnt == ssf_pkg::BITS_PER_BYTE)
                  begin
                     // release for the master's ninth-clock nack
                     next_l.sda_oe = 1'b0;
                     next_l.st = ssf_pkg::LS_WAIT;
                  end
                  else
                  begin
                     next_l.sda_oe = ~l.tx[7];
                     next_l.tx = {l.tx[6:0], 1'b0};
                     next_l.cnt = l.cnt + 4'h1;
                  end
               end
            end
            default: next_l.st = ssf_pkg::LS_IDLE;
         endcase
      end
   end
   always_ff @(posedge link_clk or negedge rst_b)
   begin
      if (!rst_b)
         l <= LINK_RST;
      else
         l <= next_l;
   end
   // system side: comparators pass two flops before any decision
   always_comb
   begin
      next_c = c;
      next_c.cmp_m = {lamp_b_on, lamp_a_on, dimming_chop, low_side_phase, supply_lockout,
         sec_under_v, prim_over_i, sec_over_i, sec_over_v, lamp_b_low, lamp_a_low};
      next_c.cmp_s = c.cmp_m;
      next_c.en_s = {c.en_s[0], l.ctrl[ssf_pkg::CTRL_ENABLE_BIT]};
      if (!c.en_s[1])
      begin
         // shutdown: latch held clear, timers idle
         next_c.timer = '0;
         next_c.uv_cnt = 17'h00000;
         next_c.lamp_fault = 1'b0;
         next_c.oc_fault = 1'b0;
         next_c.uv_shut = 1'b0;
      end
      else if (!(c.lamp_fault || c.oc_fault))
      begin
         if (c.timer >= FAULT_LIMIT)
         begin
            next_c.oc_fault = c.cmp_s[ssf_pkg::CMP_SEC_OC];
            next_c.lamp_fault = ~c.cmp_s[ssf_pkg::CMP_SEC_OC];
            next_c.timer = '0;
         end
         else if (c.cmp_s[ssf_pkg::CMP_SEC_OC])
            next_c.timer = c.timer + ssf_pkg::FAST_STEP;
         else if (c.cmp_s[ssf_pkg::CMP_LAMP_A_LOW] || c.cmp_s[ssf_pkg::CMP_LAMP_B_LOW])
            next_c.timer = c.timer + ssf_pkg::SLOW_STEP;
         else
            next_c.timer = '0;
      end
      if (c.en_s[1])
      begin
         // any gap in the under-voltage restarts the wait
         if (c.cmp_s[ssf_pkg::CMP_DIM_ON] && c.cmp_s[ssf_pkg::CMP_SEC_UV])
         begin
            if (32'(c.uv_cnt) >= UV_DELAY - 1)
               next_c.uv_shut = 1'b1;
            else
               next_c.uv_cnt = c.uv_cnt + 17'h00001;
         end
         else
            next_c.uv_cnt = 17'h00000;
      end
      // the regulator stays up through every fault and drops only in shutdown; faults stop only the drivers
      next_c.hs_en = c.en_s[1] & ~c.lamp_fault & ~c.oc_fault & ~c.uv_shut
         & ~c.cmp_s[ssf_pkg::CMP_SUPPLY_LOW];
      next_c.ls_en = next_c.hs_en;
      next_c.hs_cut = c.cmp_s[ssf_pkg::CMP_LOW_PHASE] & c.cmp_s[ssf_pkg::CMP_PRIM_OC];
      next_c.disch = c.en_s[1]
         & (c.cmp_s[ssf_pkg::CMP_SEC_OV] | c.cmp_s[ssf_pkg::CMP_SEC_OC]);
      next_c.lss = c.en_s[1];
   end
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         c <= '0;
      else
         c <= next_c;
   end
   assign sda_out = l.sda_out;
   assign sda_oe = l.sda_oe;
   assign brightness_level = l.bright;
   assign high_side_en = c.hs_en;
   assign low_side_en = c.ls_en;
   assign high_side_cut = c.hs_cut;
   assign comp_discharge = c.disch;
   assign light_sensor_supply = c.lss;
   sequence s_lamp_out_run;
      c.en_s[1] && !c.lamp_fault && !c.oc_fault && !c.cmp_s[ssf_pkg::CMP_SEC_OC]
         && (c.cmp_s[ssf_pkg::CMP_LAMP_A_LOW] || c.cmp_s[ssf_pkg::CMP_LAMP_B_LOW])
         && c.timer < FAULT_LIMIT;
   endsequence
   sequence s_oc_run;
      c.en_s[1] && !c.lamp_fault && !c.oc_fault && c.cmp_s[ssf_pkg::CMP_SEC_OC]
         && c.timer < FAULT_LIMIT;
   endsequence
   property p_slow_rate;
      @(posedge sys_clk) disable iff (!rst_b)
      s_lamp_out_run |=> c.timer == $past(c.timer) + 24'h000001;
   endproperty
   a_slow_rate: assert property (p_slow_rate) else $error("slow timer step wrong");
   property p_fast_rate;
      @(posedge sys_clk) disable iff (!rst_b)
      s_oc_run |=> c.timer == $past(c.timer) + ssf_pkg::FAST_STEP;
   endproperty
   a_fast_rate: assert property (p_fast_rate) else $error("fast timer step wrong");
   property p_latch;
      @(posedge sys_clk) disable iff (!rst_b)
      c.en_s[1] && !c.lamp_fault && !c.oc_fault && c.timer >= FAULT_LIMIT
         |=> (c.lamp_fault || c.oc_fault) ##1 !high_side_en && !low_side_en;
   endproperty
   a_latch: assert property (p_latch) else $error("terminal count did not stop");
   property p_shutdown_clear;
      @(posedge sys_clk) disable iff (!rst_b)
      !c.en_s[1] |=> !c.lamp_fault && !c.oc_fault && !high_side_en && !light_sensor_supply;
   endproperty
   a_shutdown_clear: assert property (p_shutdown_clear) else $error("shutdown kept state");
   property p_lockout;
      @(posedge sys_clk) disable iff (!rst_b)
      c.cmp_s[ssf_pkg::CMP_SUPPLY_LOW] |=> !high_side_en && !low_side_en;
   endproperty
   a_lockout: assert property (p_lockout) else $error("drivers on in lockout");
   property p_discharge;
      @(posedge sys_clk) disable iff (!rst_b)
      c.en_s[1] && $rose(c.cmp_s[ssf_pkg::CMP_SEC_OV]) |=> comp_discharge;
   endproperty
   a_discharge: assert property (p_discharge) else $error("no discharge on over-voltage");
   property p_hs_cut;
      @(posedge sys_clk) disable iff (!rst_b)
      c.cmp_s[ssf_pkg::CMP_LOW_PHASE] && c.cmp_s[ssf_pkg::CMP_PRIM_OC] |=> high_side_cut;
   endproperty
   a_hs_cut: assert property (p_hs_cut) else $error("high side not cut");
   property p_cmd_nack;
      @(posedge link_clk) disable iff (!rst_b)
      l.st == ssf_pkg::LS_CMD && scl_fall && !bus_start && !bus_stop
         && l.cnt == ssf_pkg::BITS_PER_BYTE && l.sh > ssf_pkg::CMD_LAST
         |=> !sda_oe && l.st == ssf_pkg::LS_WAIT;
   endproperty
   a_cmd_nack: assert property (p_cmd_nack) else $error("bad command acknowledged");
   property p_discard;
      @(posedge link_clk) disable iff (!rst_b)
      (bus_start || bus_stop) && !l.have_data |=> $stable(l.ctrl) && $stable(l.bright);
   endproperty
   a_discard: assert property (p_discard) else $error("partial write committed");
endmodule

// File: ssf_pkg.sv
// constants and types of the lamp inverter supervisor with its two-wire slave
// assumes one design file imports nothing and scopes every name explicitly
package ssf_pkg;
   // two-wire slave address and command range
   localparam logic [6:0] SLAVE_ADDR = 7'h2C;
   localparam logic [7:0] CMD_LAST = 8'h06;
   localparam logic [2:0] OFF_BRIGHT = 3'h0;
   localparam logic [2:0] OFF_CTRL = 3'h1;
   localparam logic [2:0] OFF_STATUS = 3'h2;
   localparam logic [2:0] OFF_ID = 3'h3;
   localparam logic [2:0] OFF_LIGHT = 3'h4;
   localparam logic [2:0] OFF_LOW = 3'h5;
   localparam logic [2:0] OFF_HIGH = 3'h6;
   // power-on values and control write mask
   localparam logic [7:0] BRIGHT_RST = 8'hFF;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] LOW_RST = 8'h00;
   localparam logic [7:0] HIGH_RST = 8'hFF;
   localparam logic [7:0] CTRL_MASK = 8'h3F;
   // value is arbitrary
   localparam logic [7:0] PART_ID = 8'h5A;
   // field positions
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_PWM_SEL_BIT = 1;
   localparam int CTRL_SENSOR_BIT = 3;
   localparam int STAT_FAULT_BIT = 0;
   localparam int STAT_OVC_BIT = 2;
   localparam int STAT_LAMP_BIT = 3;
   // comparator vector positions
   localparam int CMP_LAMP_A_LOW = 0;
   localparam int CMP_LAMP_B_LOW = 1;
   localparam int CMP_SEC_OV = 2;
   localparam int CMP_SEC_OC = 3;
   localparam int CMP_PRIM_OC = 4;
   localparam int CMP_SEC_UV = 5;
   localparam int CMP_SUPPLY_LOW = 6;
   localparam int CMP_LOW_PHASE = 7;
   localparam int CMP_DIM_ON = 8;
   localparam int CMP_LAMP_A_ON = 9;
   localparam int CMP_LAMP_B_ON = 10;
   localparam int CMP_N = 11;
   // timing: 200 MHz system clock
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned UV_TIME_US = 250;
   localparam int unsigned UV_CYCLES = UV_TIME_US * CLK_MHZ;
   // fault timer: steps follow the 1 uA / 135 uA charge currents
   localparam int TIMER_W = 24;
   localparam int unsigned TIMER_LIMIT = 1048576;
   localparam logic [23:0] SLOW_STEP = 24'h000001;
   localparam logic [23:0] FAST_STEP = 24'h000087;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   typedef enum logic [3:0] {
      LS_IDLE, LS_ADDR, LS_ADDR_ACK, LS_CMD, LS_CMD_ACK,
      LS_DATA, LS_DATA_ACK, LS_READ, LS_WAIT
   } ssf_link_st_t;
endpackage

// File: ssf_host.sv
// bus master model of the system host on the two-wire link
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/10ps
module ssf_host #(
   parameter int QTR = 16
) (
   // timing
   input wire logic clk,
   // bus
   input wire logic sda,
   output logic scl,
   output logic sda_pull
);
   // clock stands high between frames
   initial
   begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic q();
      repeat (QTR) @(negedge clk);
   endtask
   // serves as start and repeated start
   task automatic start_c();
      sda_pull = 1'b0;
      q();
      scl = 1'b1;
      q();
      sda_pull = 1'b1;
      q();
      scl = 1'b0;
      q();
   endtask
   task automatic stop_c();
      sda_pull = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_pull = 1'b0;
      q();
   endtask
   // data moves only while clock is low, sampled one quarter after the rise
   task automatic bit_c(input logic b, output logic r);
      sda_pull = ~b;
      q();
      scl = 1'b1;
      q();
      r = sda;
      q();
      scl = 1'b0;
      q();
   endtask
   // a read passes FF: released data line, ninth bit is the nack
   task automatic byte_c(input logic [7:0] w, output logic [7:0] r, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--)
      begin
         bit_c(w[i], r[i]);
      end
      bit_c(1'b1, a);
      ack = (a === 1'b0);
   endtask
endmodule

// File: tb_smbus_slave_fault_supervisor.sv
// self-checking bench of the lamp supervisor and its two-wire slave
// assumes the host model masters the bus; short fault counts via parameters
`timescale 1ns/10ps
module tb_smbus_slave_fault_supervisor;
   localparam int unsigned LIM = 200;
   localparam int unsigned UVD = 20;
   localparam logic [6:0] AD = ssf_pkg::SLAVE_ADDR;
   logic sys_clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [10:0] cmp = 11'h000;
   logic [7:0] code = 8'h00;
   logic [7:0] bright;
   logic scl, pull, sda_out, sda_oe, hs_en, ls_en, hs_cut, disch, sup;
   logic [31:0] rng = 32'h0000002F;
   int fails = 0;
   int n_tests = 0;
   int cyc = 0;
   // open drain wire with pull-up
   wire sda = ~(pull | (sda_oe & ~sda_out));
   always #2.5 sys_clk = ~sys_clk;
   // link clock offset so its edges never line up with the system clock
   initial
   begin
      #1.3;
      forever #16 link_clk = ~link_clk;
   end
   ssf_host u_ssf_host (.clk(sys_clk), .sda(sda), .scl(scl), .sda_pull(pull));
   ssf_supervisor #(.FAULT_LIMIT(LIM), .UV_DELAY(UVD)) u_ssf_supervisor (
      .sys_clk(sys_clk), .rst_b(rst_b), .link_clk(link_clk), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe),
      .lamp_a_low(cmp[ssf_pkg::CMP_LAMP_A_LOW]), .lamp_b_low(cmp[ssf_pkg::CMP_LAMP_B_LOW]),
      .sec_over_v(cmp[ssf_pkg::CMP_SEC_OV]), .sec_over_i(cmp[ssf_pkg::CMP_SEC_OC]),
      .prim_over_i(cmp[ssf_pkg::CMP_PRIM_OC]), .sec_under_v(cmp[ssf_pkg::CMP_SEC_UV]),
      .supply_lockout(cmp[ssf_pkg::CMP_SUPPLY_LOW]), .low_side_phase(cmp[ssf_pkg::CMP_LOW_PHASE]),
      .dimming_chop(cmp[ssf_pkg::CMP_DIM_ON]), .lamp_a_on(cmp[ssf_pkg::CMP_LAMP_A_ON]),
      .lamp_b_on(cmp[ssf_pkg::CMP_LAMP_B_ON]), .light_sensor_code(code),
      .brightness_level(bright), .high_side_en(hs_en), .low_side_en(ls_en),
      .high_side_cut(hs_cut), .comp_discharge(disch), .light_sensor_supply(sup));
   function automatic logic [7:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng[7:0];
   endfunction
   function automatic logic [7:0] rst_val(input int a);
      case (a)
         0, 6: return 8'hFF;
         3: return ssf_pkg::PART_ID;
         4: return code;
         default: return 8'h00;
      endcase
   endfunction
   function automatic logic [7:0] stat(input logic lf, input logic oc);
      return {4'h0, cmp[ssf_pkg::CMP_LAMP_A_ON] & cmp[ssf_pkg::CMP_LAMP_B_ON], oc, 1'b0, lf | oc};
   endfunction
   task automatic print_verdict();
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wait_c(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // high side, low side, sensor supply
   task automatic outs(input logic [2:0] e);
      chk({5'h00, hs_en, ls_en, sup}, {5'h00, e});
   endtask
   task automatic wr(input logic [6:0] ad, input logic [7:0] c, input logic [7:0] d,
                     output logic ok);
      logic [7:0] r;
      logic a0, a1, a2;
      u_ssf_host.start_c();
      u_ssf_host.byte_c({ad, 1'b0}, r, a0);
      u_ssf_host.byte_c(c, r, a1);
      u_ssf_host.byte_c(d, r, a2);
      u_ssf_host.stop_c();
      ok = a0 & a1 & a2;
      wait_c(20);
   endtask
   task automatic rd(input logic [7:0] c, output logic [7:0] d);
      logic [7:0] r;
      logic a;
      u_ssf_host.start_c();
      u_ssf_host.byte_c({AD, 1'b0}, r, a);
      u_ssf_host.byte_c(c, r, a);
      u_ssf_host.start_c();
      u_ssf_host.byte_c({AD, 1'b1}, r, a);
      u_ssf_host.byte_c(8'hFF, d, a);
      u_ssf_host.stop_c();
      wait_c(4);
   endtask
   // ceiling sized for about 74000 cycles of traffic
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         fails++;
         print_verdict();
      end
   end
   initial
   begin
      logic [7:0] d, v, vb, t;
      logic ok;
      int li;
      code = xs();
      // five link cycles so both domains see the reset
      repeat (5) @(posedge link_clk);
      @(negedge sys_clk);
      rst_b = 1'b1;
      wait_c(20);
      chk(bright, 8'hFF);
      outs(3'b000);
      for (int a = 0; a < 7; a++)
      begin
         rd(a[7:0], d);
         chk(d, rst_val(a));
      end
      wr(AD ^ 7'h01, 8'h05, 8'h11, ok);
      chk({7'h00, ok}, 8'h00);
      for (int c = 7; c < 256; c += 83)
      begin
         wr(AD, c[7:0], 8'h22, ok);
         chk({7'h00, ok}, 8'h00);
      end
      rd(8'h05, d);
      chk(d, 8'h00);
      wr(AD, 8'h01, 8'hC1, ok);
      chk({7'h00, ok}, 8'h01);
      rd(8'h01, d);
      chk(d, 8'hC1 & ssf_pkg::CTRL_MASK);
      outs(3'b111);
      for (int i = 0; i < 3; i++)
      begin
         v = xs();
         t = (i == 0) ? 8'h00 : 8'h04 + i[7:0];
         if (i == 0)
            vb = v;
         wr(AD, t, v, ok);
         chk({7'h00, ok}, 8'h01);
         rd(t, d);
         chk(d, v);
      end
      chk(bright, vb);
      // data byte cut short by a stop
      u_ssf_host.start_c();
      u_ssf_host.byte_c({AD, 1'b0}, d, ok);
      u_ssf_host.byte_c(8'h00, d, ok);
      for (int i = 0; i < 4; i++)
      begin
         u_ssf_host.bit_c(1'b0, ok);
      end
      u_ssf_host.stop_c();
      wait_c(20);
      chk(bright, vb);
      // brightness writes ignored outside bus-set mode; read-only writes acked, no effect
      wr(AD, 8'h01, 8'h03, ok);
      wr(AD, 8'h00, ~vb, ok);
      rd(8'h00, d);
      chk(d, vb);
      wr(AD, 8'h03, ~ssf_pkg::PART_ID, ok);
      chk({7'h00, ok}, 8'h01);
      rd(8'h03, d);
      chk(d, ssf_pkg::PART_ID);
      wr(AD, 8'h01, 8'h01, ok);
      cmp[ssf_pkg::CMP_LAMP_A_ON] = 1'b1;
      cmp[ssf_pkg::CMP_LAMP_B_ON] = 1'b1;
      cmp[ssf_pkg::CMP_SUPPLY_LOW] = 1'b1;
      wait_c(5);
      outs(3'b001);
      cmp[ssf_pkg::CMP_SUPPLY_LOW] = 1'b0;
      cmp[ssf_pkg::CMP_PRIM_OC] = 1'b1;
      wait_c(5);
      chk({7'h00, hs_cut}, 8'h00);
      cmp[ssf_pkg::CMP_LOW_PHASE] = 1'b1;
      wait_c(5);
      chk({7'h00, hs_cut}, 8'h01);
      cmp[ssf_pkg::CMP_PRIM_OC] = 1'b0;
      cmp[ssf_pkg::CMP_SEC_OV] = 1'b1;
      wait_c(5);
      chk({7'h00, disch}, 8'h01);
      cmp[ssf_pkg::CMP_SEC_OV] = 1'b0;
      wait_c(5);
      chk({7'h00, disch}, 8'h00);
      li = xs() & 8'h01;
      cmp[li] = 1'b1;
      wait_c(LIM - 50);
      outs(3'b111);
      wait_c(60);
      outs(3'b001);
      cmp[li] = 1'b0;
      rd(8'h02, d);
      chk(d, stat(1'b1, 1'b0));
      wr(AD, 8'h01, 8'h00, ok);
      outs(3'b000);
      rd(8'h02, d);
      chk(d, stat(1'b0, 1'b0));
      // lamp low through a long shutdown must not latch
      cmp[li] = 1'b1;
      wait_c(LIM + 50);
      wr(AD, 8'h01, 8'h01, ok);
      outs(3'b111);
      cmp[li] = 1'b0;
      cmp[ssf_pkg::CMP_SEC_OC] = 1'b1;
      wait_c(4);
      chk({7'h00, disch}, 8'h01);
      wait_c(8);
      outs(3'b001);
      cmp[ssf_pkg::CMP_SEC_OC] = 1'b0;
      rd(8'h02, d);
      chk(d, stat(1'b1, 1'b1));
      wr(AD, 8'h01, 8'h00, ok);
      wr(AD, 8'h01, 8'h01, ok);
      outs(3'b111);
      cmp[ssf_pkg::CMP_DIM_ON] = 1'b1;
      repeat (2)
      begin
         cmp[ssf_pkg::CMP_SEC_UV] = 1'b1;
         wait_c(UVD - 5);
         cmp[ssf_pkg::CMP_SEC_UV] = 1'b0;
         wait_c(3);
      end
      outs(3'b111);
      cmp[ssf_pkg::CMP_SEC_UV] = 1'b1;
      wait_c(UVD + 10);
      outs(3'b001);
      print_verdict();
   end
endmodule
